// ===== src/opt_pkg.sv
// Contract
// - mode 00 single, 01 delayed, 1X continuous
// - ch5 mode bits 12-13, ch4 14-15
// - ch7 mode bits 2-3, ch6 6-7
// - bit 1 picks ch7 start: group or ch6
// - group67 start: pin b, or event buses
// - group67 clock: clock bus by code
// - ch10/9/8 modes at bits 2-3/4-5/6-7
// - bit 11: pin c or event bus 3
// - group8to10 clock: codes select clock bus
// - 16-bit down-counter steps on count clock
// - reload write leaves counter untouched
// - single-shot loads reload at enable
// - delayed/continuous load reload at underflow
// - underflow reload within same clock period
// - output toggles at underflow, and at start except in delayed mode
// - delayed: two underflows, then stop
// - continuous runs until software clears enable
// - underflow request on every underflow
package opt_pkg;
  localparam int unsigned ADDR_W    = 24;
  localparam int unsigned NUM_CH    = 7;          // channels four to ten
  localparam int unsigned CNT_W     = 16;

  // register word indices; byte address is four times the index
  localparam logic [23:0] IDX_MODE45   = 24'h80_029D;
  localparam logic [23:0] IDX_CTRL67   = 24'h80_02AA;
  localparam logic [23:0] IDX_CTRL810  = 24'h80_02EA;
  localparam logic [23:0] IDX_CNT_BASE = 24'h80_0300;
  localparam logic [23:0] IDX_RL_BASE  = 24'h80_0310;
  localparam logic [23:0] IDX_ENABLE   = 24'h80_0320;
  localparam logic [23:0] IDX_STATUS   = 24'h80_0321;

  // writable bits, everything else reads zero
  localparam logic [7:0]  MASK_MODE45  = 8'hF0;
  localparam logic [15:0] MASK_CTRL67  = 16'hCECE;
  localparam logic [15:0] MASK_CTRL810 = 16'hC8FC;
  localparam logic [15:0] MASK_ENABLE  = 16'h7F7F;

  localparam logic [7:0]  RST_MODE45   = 8'h00;
  localparam logic [15:0] RST_CTRL     = 16'h0000;
  localparam logic [15:0] RST_CNT      = 16'h0000;

  // field positions, mode45 sits in the low byte (bit n of the halfword at n-8)
  localparam int unsigned CH5_MODE_LSB   = 4;
  localparam int unsigned CH4_MODE_LSB   = 6;
  localparam int unsigned CH7_MODE_LSB   = 2;
  localparam int unsigned CH6_MODE_LSB   = 6;
  localparam int unsigned CH7_SRC_BIT    = 1;
  localparam int unsigned G67_SRC_LSB    = 9;
  localparam int unsigned CLK_SEL_LSB    = 14;
  localparam int unsigned CH10_MODE_LSB  = 2;
  localparam int unsigned CH9_MODE_LSB   = 4;
  localparam int unsigned CH8_MODE_LSB   = 6;
  localparam int unsigned G810_SRC_BIT   = 11;
  localparam int unsigned PERMIT_LSB     = 8;

  localparam logic [1:0] MODE_SINGLE  = 2'b00;
  localparam logic [1:0] MODE_DELAYED = 2'b01;
endpackage

// ===== src/chan_if.sv
`timescale 1ns/100ps
interface chan_if;
  logic [1:0]  mode;
  logic        tick;
  logic        run;
  logic        start;
  logic        cnt_wr;
  logic        rl_wr;
  logic [15:0] wr_data;
  logic [15:0] count;
  logic [15:0] reload;
  logic        out_ff;
  logic        underflow;
  logic        done;

  modport ctrl (output mode, tick, run, start, cnt_wr, rl_wr, wr_data,
                input  count, reload, out_ff, underflow, done);
  modport chan (input  mode, tick, run, start, cnt_wr, rl_wr, wr_data,
                output count, reload, out_ff, underflow, done);
endinterface

// ===== src/timer_channel.sv
`timescale 1ns/100ps
module timer_channel (
  input  wire logic clk_in,      // system clock
  input  wire logic sys_rst_in,  // synchronous reset, high
  chan_if.chan      ch           // control and state of one channel
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] rl_reg;
  logic        out_reg;
  logic        out_next;
  logic        first_reg;
  logic        first_next;
  logic        uf_reg;
  logic        done_reg;

  wire is_single  = (ch.mode == opt_pkg::MODE_SINGLE);
  wire is_delayed = (ch.mode == opt_pkg::MODE_DELAYED);
  wire is_cont    = ch.mode[1];
  wire step       = ch.run && ch.tick && !ch.start;
  wire at_zero    = (cnt_reg == 16'h0000);
  wire uf_hit     = step && at_zero;
  // delayed mode finishes on its second underflow, single-shot on its first
  wire finish     = uf_hit && (is_single || (is_delayed && !first_reg));

  always_comb begin
    cnt_next   = cnt_reg;
    out_next   = out_reg;
    first_next = first_reg;
    if (ch.start) begin
      first_next = 1'b1;
      if (!is_delayed) begin
        out_next = ~out_reg;
      end
      if (is_single) begin
        cnt_next = rl_reg;
      end
    end else if (uf_hit) begin
      out_next   = ~out_reg;
      first_next = 1'b0;
      if (is_cont || (is_delayed && first_reg)) begin
        cnt_next = rl_reg;
      end
    end else if (step) begin
      cnt_next = cnt_reg - 16'h0001;
    end
    // a direct counter write overrides counting in that cycle
    if (ch.cnt_wr) begin
      cnt_next = ch.wr_data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_reg   <= opt_pkg::RST_CNT;
      rl_reg    <= opt_pkg::RST_CNT;
      out_reg   <= 1'b0;
      first_reg <= 1'b0;
      uf_reg    <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      out_reg   <= out_next;
      first_reg <= first_next;
      uf_reg    <= uf_hit;
      done_reg  <= finish;
      if (ch.rl_wr) begin
        rl_reg <= ch.wr_data;
      end
    end
  end

  assign ch.count     = cnt_reg;
  assign ch.reload    = rl_reg;
  assign ch.out_ff    = out_reg;
  assign ch.underflow = uf_reg;
  assign ch.done      = done_reg;
endmodule

// ===== src/output_pulse_timer_group.sv
`timescale 1ns/100ps
module output_pulse_timer_group (
  input  wire logic        clk_in,                // system clock, 100 MHz
  input  wire logic        sys_rst_in,            // synchronous reset, high
  input  wire logic [23:0] avs_address_in,        // word address
  input  wire logic        avs_read_in,           // read request
  input  wire logic        avs_write_in,          // write request
  input  wire logic [31:0] avs_writedata_in,      // write data
  input  wire logic [3:0]  avs_byteenable_in,     // byte lanes
  output logic      [31:0] avs_readdata_out,      // read data
  output logic             avs_waitrequest_out,   // stall
  input  wire logic [3:0]  clock_bus_in,          // count clock ticks
  input  wire logic [3:0]  event_bus_in,          // input event buses
  input  wire logic        ext_trigger_pin_b_in,  // start pin, group 6/7
  input  wire logic        ext_trigger_pin_c_in,  // start pin, group 8-10
  output logic      [6:0]  pulse_out,             // output flip-flops ch4..ch10
  output logic      [6:0]  underflow_out          // underflow requests ch4..ch10
);
  localparam int unsigned N = opt_pkg::NUM_CH;

  function automatic logic sel_clk(input logic [1:0] code, input logic [3:0] bus);
    sel_clk = bus[code];
  endfunction

  function automatic logic [15:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [15:0] keep);
    merge = (old_v & ~keep) | (new_v & keep);
  endfunction

  logic [7:0]  mode45_reg;
  logic [15:0] ctrl67_reg;
  logic [15:0] ctrl810_reg;
  logic [15:0] enable_reg;
  logic [15:0] enable_next;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        pin_b_d;
  logic        pin_c_d;
  logic [3:0]  evt_d;
  logic        ch6_out_d;
  logic [6:0]  cen_d;

  chan_if chs[N] ();

  // bus handshake: one wait cycle, then the answer
  wire         req       = avs_read_in || avs_write_in;
  wire         wr_fire   = avs_write_in && ack_reg;
  wire [15:0]  be_mask   = lane_mask(avs_byteenable_in);
  wire [15:0]  wdata     = avs_writedata_in[15:0];
  wire         hit_m45   = (avs_address_in == opt_pkg::IDX_MODE45);
  wire         hit_c67   = (avs_address_in == opt_pkg::IDX_CTRL67);
  wire         hit_c810  = (avs_address_in == opt_pkg::IDX_CTRL810);
  wire         hit_en    = (avs_address_in == opt_pkg::IDX_ENABLE);
  wire         hit_st    = (avs_address_in == opt_pkg::IDX_STATUS);
  wire [23:0]  cnt_off   = avs_address_in - opt_pkg::IDX_CNT_BASE;
  wire [23:0]  rl_off    = avs_address_in - opt_pkg::IDX_RL_BASE;
  wire         hit_cnt   = (cnt_off < 24'(N));
  wire         hit_rl    = (rl_off < 24'(N));
  wire [2:0]   cnt_idx   = cnt_off[2:0];
  wire [2:0]   rl_idx    = rl_off[2:0];

  // mode fields per channel, index 0 is channel four
  wire [1:0] mode_ch [N];
  assign mode_ch[0] = mode45_reg[opt_pkg::CH4_MODE_LSB +: 2];
  assign mode_ch[1] = mode45_reg[opt_pkg::CH5_MODE_LSB +: 2];
  assign mode_ch[2] = ctrl67_reg[opt_pkg::CH6_MODE_LSB +: 2];
  assign mode_ch[3] = ctrl67_reg[opt_pkg::CH7_MODE_LSB +: 2];
  assign mode_ch[4] = ctrl810_reg[opt_pkg::CH8_MODE_LSB +: 2];
  assign mode_ch[5] = ctrl810_reg[opt_pkg::CH9_MODE_LSB +: 2];
  assign mode_ch[6] = ctrl810_reg[opt_pkg::CH10_MODE_LSB +: 2];

  // count clocks; a two-bit code indexes all four buses, so 11 is bus 3
  wire [1:0] cks67  = ctrl67_reg[opt_pkg::CLK_SEL_LSB +: 2];
  wire [1:0] cks810 = ctrl810_reg[opt_pkg::CLK_SEL_LSB +: 2];
  wire       tick45  = clock_bus_in[0];
  wire       tick67  = sel_clk(cks67, clock_bus_in);
  wire       tick810 = sel_clk(cks810, clock_bus_in);

  // start sources, taken on rising edges
  wire [2:0] src67    = ctrl67_reg[opt_pkg::G67_SRC_LSB +: 3];
  wire       g67_lvl  = src67[2] ? event_bus_in[src67[1:0]]
                                 : ext_trigger_pin_b_in;
  wire       g67_prev = src67[2] ? evt_d[src67[1:0]] : pin_b_d;
  wire       g67_edge = g67_lvl && !g67_prev;
  wire       g810_sel = ctrl810_reg[opt_pkg::G810_SRC_BIT];
  wire       g810_edge = g810_sel ? (event_bus_in[3] && !evt_d[3])
                                  : (ext_trigger_pin_c_in && !pin_c_d);
  wire       ch6_edge = chs[2].out_ff && !ch6_out_d;
  wire       ch7_edge = ctrl67_reg[opt_pkg::CH7_SRC_BIT] ? ch6_edge : g67_edge;

  wire [6:0] trig   = {g810_edge, g810_edge, g810_edge, ch7_edge, g67_edge, 2'b00};
  wire [6:0] permit = enable_reg[opt_pkg::PERMIT_LSB +: 7];
  wire [6:0] cen    = enable_reg[6:0];

  wire [6:0]  done_vec;
  wire [6:0]  out_vec;
  wire [6:0]  uf_vec;
  wire [15:0] cnt_rd [N];
  wire [15:0] rl_rd  [N];

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_ch
      wire tick_g = (g < 2) ? tick45 : ((g < 4) ? tick67 : tick810);
      assign chs[g].mode    = mode_ch[g];
      assign chs[g].tick    = tick_g;
      assign chs[g].run     = cen[g];
      assign chs[g].start   = cen[g] && !cen_d[g];
      assign chs[g].cnt_wr  = wr_fire && hit_cnt && (cnt_idx == 3'(g));
      assign chs[g].rl_wr   = wr_fire && hit_rl && (rl_idx == 3'(g));
      assign chs[g].wr_data = merge(g == 0 ? 16'h0000 : 16'h0000, wdata, be_mask)
                              | (chs[g].cnt_wr ? (chs[g].count & ~be_mask)
                                               : (chs[g].reload & ~be_mask));
      assign done_vec[g] = chs[g].done;
      assign out_vec[g]  = chs[g].out_ff;
      assign uf_vec[g]   = chs[g].underflow;
      assign cnt_rd[g]   = chs[g].count;
      assign rl_rd[g]    = chs[g].reload;
      timer_channel u_ch (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .ch         (chs[g])
      );
    end
  endgenerate

  // a software write wins over a same-cycle hardware stop; triggers set last
  wire [15:0] en_wr   = merge(enable_reg, wdata, be_mask) & opt_pkg::MASK_ENABLE;
  wire [15:0] m45_wr  = merge({8'h00, mode45_reg}, wdata, be_mask)
                        & {8'h00, opt_pkg::MASK_MODE45};
  wire [15:0] en_hw   = enable_reg & ~{9'h000, done_vec};
  wire [15:0] en_base = (wr_fire && hit_en) ? en_wr : en_hw;
  assign enable_next  = en_base | {9'h000, trig & permit};

  wire [15:0] rd_half =
      hit_m45  ? {8'h00, mode45_reg} :
      hit_c67  ? ctrl67_reg :
      hit_c810 ? ctrl810_reg :
      hit_en   ? enable_reg :
      hit_st   ? {9'h000, out_vec} :
      hit_cnt  ? cnt_rd[cnt_idx] :
      hit_rl   ? rl_rd[rl_idx] : 16'h0000;
  assign rdata_next = {16'h0000, rd_half};

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= req && !ack_reg;
      rdata_reg <= rdata_next;
    end
  end

  // mode writes are honoured at once; keeping the channel idle is software's job
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode45_reg  <= opt_pkg::RST_MODE45;
      ctrl67_reg  <= opt_pkg::RST_CTRL;
      ctrl810_reg <= opt_pkg::RST_CTRL;
    end else if (wr_fire) begin
      if (hit_m45) begin
        mode45_reg <= m45_wr[7:0];
      end
      if (hit_c67) begin
        ctrl67_reg <= merge(ctrl67_reg, wdata, be_mask) & opt_pkg::MASK_CTRL67;
      end
      if (hit_c810) begin
        ctrl810_reg <= merge(ctrl810_reg, wdata, be_mask) & opt_pkg::MASK_CTRL810;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      enable_reg <= opt_pkg::RST_CTRL;
      cen_d      <= 7'h00;
      pin_b_d    <= 1'b0;
      pin_c_d    <= 1'b0;
      evt_d      <= 4'h0;
      ch6_out_d  <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      cen_d      <= enable_reg[6:0];
      pin_b_d    <= ext_trigger_pin_b_in;
      pin_c_d    <= ext_trigger_pin_c_in;
      evt_d      <= event_bus_in;
      ch6_out_d  <= chs[2].out_ff;
    end
  end

  assign avs_waitrequest_out = req && !ack_reg;
  assign avs_readdata_out    = rdata_reg;
  assign pulse_out           = out_vec;
  assign underflow_out       = uf_vec;
endmodule

// ===== verif/opt_monitor.sv
`timescale 1ns/100ps
module opt_monitor (
  input wire logic        clk_in,               // clock
  input wire logic        sys_rst_in,           // reset
  input wire logic [23:0] avs_address_in,       // address
  input wire logic        avs_read_in,          // read
  input wire logic        avs_write_in,         // write
  input wire logic [31:0] avs_writedata_in,     // wdata
  input wire logic [3:0]  avs_byteenable_in,    // lanes
  input wire logic [31:0] avs_readdata_out,     // rdata
  input wire logic        avs_waitrequest_out,  // stall
  input wire logic [3:0]  clock_bus_in,         // ticks
  input wire logic [3:0]  event_bus_in,         // events
  input wire logic        ext_trigger_pin_b_in, // pin b
  input wire logic        ext_trigger_pin_c_in, // pin c
  input wire logic [6:0]  pulse_out,            // outputs
  input wire logic [6:0]  underflow_out         // underflows
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic req = avs_read_in || avs_write_in;
  wire logic ack = avs_read_in && !avs_waitrequest_out;
  // bits that carry nothing in each control register
  wire logic [15:0] rsv = avs_address_in == opt_pkg::IDX_MODE45 ? 16'hFF0F :
    avs_address_in == opt_pkg::IDX_CTRL67 ? 16'h3131 :
    avs_address_in == opt_pkg::IDX_CTRL810 ? 16'h3703 : 16'h0000;
  sequence s_rise;
    $rose(req);
  endsequence
  sequence s_wait_one;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  chk_wait_one: assert property (s_rise |-> s_wait_one)
    else $error("request not answered after one wait cycle");
  chk_wait_idle: assert property (!req |-> !avs_waitrequest_out)
    else $error("stall raised without a request");
  chk_read_upper: assert property (ack |-> avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_reserved_zero: assert property (ack |-> (avs_readdata_out[15:0] & rsv) == 16'h0000)
    else $error("reserved control bits read nonzero");
  chk_reset_quiet: assert property (disable iff (1'b0)
    $fell(sys_rst_in) |-> pulse_out == 7'h00 && underflow_out == 7'h00)
    else $error("outputs active after reset");
  for (genvar i = 0; i < 7; i++) begin : g_ch
    chk_uf_tick: assert property ($rose(underflow_out[i]) |-> $past(|clock_bus_in))
      else $error("underflow without a count clock tick");
    chk_uf_toggle: assert property ($rose(underflow_out[i]) |->
      pulse_out[i] != $past(pulse_out[i]))
      else $error("underflow did not toggle the output");
    chk_uf_one: assert property (underflow_out[i] |=>
      !underflow_out[i] || $past(|clock_bus_in))
      else $error("underflow request longer than one cycle");
  end
endmodule
bind output_pulse_timer_group opt_monitor opt_monitor_inst (
  .clk_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .clock_bus_in, .event_bus_in, .ext_trigger_pin_b_in, .ext_trigger_pin_c_in,
  .pulse_out, .underflow_out
);

// ===== verif/tick_event_source.sv
`timescale 1ns/100ps
module tick_event_source (
  input  wire logic       clk_in,         // clock
  input  wire logic       sys_rst_in,     // reset
  input  wire logic       run_in,         // ticks flow while high
  input  wire logic       fire_in,        // raise one start line
  input  wire logic [2:0] line_in,        // 0-3 event, 4 pin b, 5 pin c
  output logic      [3:0] clock_bus_out,  // one-cycle ticks
  output logic      [3:0] event_bus_out,  // event buses
  output logic            pin_b_out,      // pin b
  output logic            pin_c_out       // pin c
);
  int         cnt = 0;
  logic [3:0] tick_reg = 4'h0;
  logic [5:0] line_reg = 6'h00;
  logic [2:0] hold_reg = 3'h0;
  // bus k ticks every k+3 cycles, so a wrong bus choice changes the count
  always @(posedge clk_in) begin
    cnt <= run_in ? (cnt + 1) % 60 : 0;
    for (int k = 0; k < 4; k++) begin
      tick_reg[k] <= run_in && cnt % (k + 3) == k + 2;
    end
    if (sys_rst_in || (hold_reg == 3'h0 && !fire_in)) begin
      line_reg <= 6'h00;
    end else if (fire_in) begin
      line_reg <= 6'(1 << line_in);
      hold_reg <= 3'h4;
    end else begin
      hold_reg <= hold_reg - 3'h1;
    end
  end
  assign clock_bus_out = tick_reg;
  assign event_bus_out = line_reg[3:0];
  assign pin_b_out = line_reg[4];
  assign pin_c_out = line_reg[5];
endmodule

// ===== verif/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module tb;
  localparam logic [23:0] RA [4] = '{opt_pkg::IDX_MODE45, opt_pkg::IDX_CTRL67,
    opt_pkg::IDX_CTRL810, opt_pkg::IDX_STATUS + 24'h00_0001};
  localparam logic [15:0] RE [4] = '{16'h00F0, 16'hCECE, 16'hC8FC, 16'h0000};
  localparam int NL [7] = '{3, 2, 2, 2, 2, 4, 5};
  localparam int SL [7] = '{4, 0, 5, 6, 7, 0, 1};
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [23:0] avs_address_in = 24'h00_0000;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [3:0]  avs_byteenable_in = 4'h3;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [3:0]  clock_bus_in;
  logic [3:0]  event_bus_in;
  logic        ext_trigger_pin_b_in;
  logic        ext_trigger_pin_c_in;
  logic [6:0]  pulse_out;
  logic [6:0]  underflow_out;
  logic        run = 1'b0;
  logic        fire = 1'b0;
  logic        clr = 1'b0;
  logic [2:0]  line = 3'h0;
  logic [15:0] q;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int ch = 0;
  int bsel = 0;
  int lim = 1;
  int pre = 0;
  int hi = 0;
  int ufc = 0;
  output_pulse_timer_group output_pulse_timer_group_inst (
    .clk_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .clock_bus_in, .event_bus_in, .ext_trigger_pin_b_in, .ext_trigger_pin_c_in,
    .pulse_out, .underflow_out
  );
  tick_event_source tick_event_source_inst (
    .clk_in, .sys_rst_in, .run_in(run), .fire_in(fire), .line_in(line),
    .clock_bus_out(clock_bus_in), .event_bus_out(event_bus_in),
    .pin_b_out(ext_trigger_pin_b_in), .pin_c_out(ext_trigger_pin_c_in)
  );
  always #5 clk_in = ~clk_in;
  // ticks of the selected bus before the first underflow and at high output, until the last underflow
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (clr) begin
      pre <= 0;
      hi <= 0;
      ufc <= 0;
    end else begin
      ufc <= ufc + int'(underflow_out[ch]);
      if (clock_bus_in[bsel] && ufc < lim) begin
        pre <= pre + int'(ufc == 0);
        hi <= hi + int'(pulse_out[ch]);
      end
    end
    if (cyc == 30000) begin
      fails++;
      conclude();
    end
  end
  function automatic int expect_ticks(input logic [1:0] m, input int c, input int r,
                                      input logic high);
    if (high) begin
      return m[1] ? c + r + 2 : r + 1;
    end
    return m == opt_pkg::MODE_SINGLE ? r + 1 : c + 1;
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= {16'h0000, d};
    avs_write_in <= w;
    avs_read_in <= !w;
    // request stands until the edge that samples waitrequest low
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    q = avs_readdata_out[15:0];
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
    fails += int'(n >= 20);
  endtask
  task automatic rd(input logic [23:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    `CHK(q, e)
  endtask
  task automatic run_ch(input int n, input logic [1:0] m, input logic [1:0] k,
                        input int c, input int r, input int src);
    int t;
    logic [15:0] v;
    logic [15:0] en;
    logic [23:0] a;
    t = n < 2 ? 6 - 2 * n : n == 2 ? 6 : n == 3 ? 2 : 14 - 2 * n;
    v = (16'(m) << t) | (n < 2 ? 16'h0000 : 16'(k) << 14);
    v = v | (n < 4 ? 16'(src < 0 ? 0 : src) << 9 : 16'(src > 0) << 11);
    a = n < 2 ? opt_pkg::IDX_MODE45 : n < 4 ? opt_pkg::IDX_CTRL67 : opt_pkg::IDX_CTRL810;
    en = src < 0 ? 16'(1 << n) : 16'(1 << (n + 8));
    ch = n;
    bsel = n < 2 ? 0 : int'(k);
    lim = m == opt_pkg::MODE_SINGLE ? 1 : m == opt_pkg::MODE_DELAYED ? 2 : 3;
    bus(1'b1, a, v);
    bus(1'b1, opt_pkg::IDX_CNT_BASE + 24'(n), 16'(c));
    bus(1'b1, opt_pkg::IDX_RL_BASE + 24'(n), 16'(r));
    rd(opt_pkg::IDX_CNT_BASE + 24'(n), 16'(c));
    clr <= 1'b1;
    line <= 3'(n < 4 ? (src >= 4 ? src - 4 : 4) : (src > 0 ? 3 : 5));
    bus(1'b1, opt_pkg::IDX_ENABLE, en);
    clr <= 1'b0;
    fire <= src >= 0;
    @(posedge clk_in);
    fire <= 1'b0;
    repeat (8) @(posedge clk_in);
    run <= 1'b1;
    t = 0;
    while (ufc < lim && t < 3000) begin
      @(negedge clk_in);
      t++;
    end
    @(posedge clk_in);
    run <= 1'b0;
    `CHK(t < 3000, 1'b1)
    `CHK(pre, expect_ticks(m, c, r, 1'b0))
    `CHK(hi, expect_ticks(m, c, r, 1'b1))
    rd(opt_pkg::IDX_ENABLE, (en & 16'hFF00) | (m[1] ? 16'(1 << n) : 16'h0000));
    bus(1'b1, opt_pkg::IDX_ENABLE, 16'h0000);
    repeat (10) @(posedge clk_in);
    `CHK(pulse_out[n], 1'b0)
    `CHK(ufc, lim)
    $display("channel %0d mode %0d source %0d done", n + 4, m, src);
  endtask
  initial begin
    logic [1:0] m;
    void'($urandom(49));
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    for (int i = 0; i < 4; i++) begin
      rd(RA[i], 16'h0000);
      bus(1'b1, RA[i], 16'hFFFF);
      rd(RA[i], RE[i]);
    end
    $display("register test done");
    // corner: zero count and zero reload first, code 11 on the last group
    for (int i = 0; i < 14; i++) begin
      m = 2'(i % 4);
      run_ch(i % 7, m, i == 6 ? 2'b11 : 2'($urandom % 4), i == 0 ? 0 : $urandom % 6,
             i == 0 ? 0 : int'(m[1]) + $urandom % 5, -1);
    end
    for (int j = 0; j < 7; j++) begin
      run_ch(NL[j], 2'b00, 2'($urandom % 4), 1 + $urandom % 4, $urandom % 4, SL[j]);
    end
    // ch7 started by the rising output of ch6, no count clock running
    bus(1'b1, opt_pkg::IDX_CTRL67, 16'h0002);
    bus(1'b1, opt_pkg::IDX_ENABLE, 16'h0804);
    repeat (2) @(posedge clk_in);
    rd(opt_pkg::IDX_ENABLE, 16'h080C);
    `CHK(pulse_out[3:2], 2'b11)
    $display("chained start test done");
    conclude();
  end
endmodule
